// [hdl/adc_convert_and_readout_control.v]
// Operation
// (R1) Format select high gives parallel bus, low gives serial output.
// (R2) Half select low drives upper 8 bits, high drives lower 4.
// (R3) Half select change with select low, read high switches bus at once.
// (R4) Select low, read/convert falling starts hold and conversion.
// (R5) Select low, read/convert rising enables bus or starts external serial.
// (R6) Scan low, read/convert low, select falling starts conversion.
// (R7) Read/convert high, select falling enables bus or starts external serial.
// (R8) Busy low from start until result latched; data valid at busy rise.
// (R9) Serial scan mode converts repeatedly through all four channels.
// (R10) Power down inhibits conversions and keeps the result.
// (R11) Power down in scan mode resets channel counter to zero.
// (R12) Host holds read/convert low 40ns to 12us to start.
// (R13) Host toggles half select to read remaining half.
// (R14) Start requests while busy is low are ignored.
// (R15) Host spaces conversion starts at least 25us apart.
// (R16) Internal clock serial sends previous result on 12 driven clock pulses.
// (R17) Serial busy stays low until conversion and transmission both finish.
// (R18) Two's complement result, serial MSB first, stable across both edges; the code changes the bit on each falling edge.
// (R19) Clock source low selects internal shift clock, high external.
// (R20) Shift clock pin is output if internal, input if external.
// (R21) Channel pins are inputs when scan low, outputs when scan high.
// (R22) Last result is held in an output register for all reads.
`timescale 1ns/10ps
`include "adc_ctrl_map.vh"
module adc_convert_and_readout_control (
  input wire CLK,
  input wire RSTN,
  input wire CS_N,
  input wire READ_CONVERT,
  input wire HALF_SELECT,
  input wire OUTPUT_FORMAT_SELECT,
  input wire CONTINUOUS_SCAN,
  input wire POWER_DOWN,
  input wire CLOCK_SOURCE_SELECT,
  input wire SHIFT_CLOCK_IN,
  output wire SHIFT_CLOCK_OUT,
  output wire SHIFT_CLOCK_OE,
  input wire CHANNEL_ADDR_HI_IN,
  input wire CHANNEL_ADDR_LO_IN,
  output wire CHANNEL_ADDR_HI_OUT,
  output wire CHANNEL_ADDR_LO_OUT,
  output wire CHANNEL_ADDR_OE,
  input wire [11:0] SAMPLE_DATA,
  output wire HOLD,
  output wire [1:0] CONV_CHANNEL,
  output wire BUSY_N,
  output wire [7:0] PARALLEL_BUS,
  output wire PARALLEL_BUS_OE,
  output wire SERIAL_OUT,
  output wire SERIAL_OUT_OE
);
  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_DONE = 3'b100;

  wire cs_n_s;
  wire rc_s;
  wire sck_s;
  wire sck_n_s;
  wire sck_tick;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg cs_n_d_reg;
  reg rc_d_reg;
  reg sck_d_reg;
  reg [15:0] conv_cnt_reg;
  reg [`RES_MSB:0] result_reg;
  reg [`RES_MSB:0] shift_reg;
  reg [3:0] bits_left_reg;
  reg sck_out_reg;
  reg serial_out_reg;
  reg [`CH_W-1:0] chan_reg;
  reg [`CH_W-1:0] conv_chan_reg;
  reg read_en_reg;
  reg pd_d_reg;
  reg [7:0] bus_reg;

  pin_sync u_cs (.clk(CLK), .rst_n(RSTN), .d(CS_N), .q(cs_n_s));
  pin_sync u_rc (.clk(CLK), .rst_n(RSTN), .d(READ_CONVERT), .q(rc_s));
  // Inverted through the synchroniser so its reset level is the idle low clock
  pin_sync u_sck (.clk(CLK), .rst_n(RSTN), .d(!SHIFT_CLOCK_IN), .q(sck_n_s));
  assign sck_s = !sck_n_s;

  wire serial_mode = !OUTPUT_FORMAT_SELECT; // (R1)
  wire ext_clk = CLOCK_SOURCE_SELECT; // (R19)
  wire rc_fall = rc_d_reg && !rc_s;
  wire rc_rise = !rc_d_reg && rc_s;
  wire cs_fall = cs_n_d_reg && !cs_n_s;
  wire scan_run = serial_mode && CONTINUOUS_SCAN && !cs_n_s && !rc_s && !POWER_DOWN; // (R9)
  // Starts are only honoured in idle, so requests during busy vanish
  wire start_req = ((!cs_n_s && rc_fall) // (R4)
    || (!CONTINUOUS_SCAN && !rc_s && cs_fall) // (R6)
    || scan_run) && !POWER_DOWN; // (R10)
  wire start = (state_reg == ST_IDLE) && start_req; // (R14)
  wire read_evt = (!cs_n_s && rc_rise) || (rc_s && cs_fall); // (R5) (R7)
  wire int_shift = serial_mode && !ext_clk; // (R16)
  wire shifting = bits_left_reg != `CNT_ZERO;
  wire conv_end = (state_reg == ST_CONV) && (conv_cnt_reg == `CONV_CYCLES - 1);
  wire sck_fall_ext = sck_d_reg && !sck_s;

  rate_div u_div (.clk(CLK), .rst_n(RSTN), .run(shifting && int_shift), .tick(sck_tick));

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (conv_end) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        // Serial busy waits for the previous result to finish shifting
        if (!(serial_mode && shifting)) begin // (R17)
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge CLK) begin
    if (!RSTN) begin
      state_reg <= ST_IDLE;
      cs_n_d_reg <= 1'b1;
      rc_d_reg <= 1'b1;
      sck_d_reg <= 1'b0;
      pd_d_reg <= 1'b0;
      conv_cnt_reg <= 16'h0000;
      result_reg <= `RES_ZERO;
      shift_reg <= `RES_ZERO;
      bits_left_reg <= `CNT_ZERO;
      sck_out_reg <= 1'b0;
      serial_out_reg <= 1'b0;
      chan_reg <= `CH_ZERO;
      conv_chan_reg <= `CH_ZERO;
      read_en_reg <= 1'b0;
      bus_reg <= `BYTE_ZERO;
    end else begin
      state_reg <= state_next;
      cs_n_d_reg <= cs_n_s;
      rc_d_reg <= rc_s;
      sck_d_reg <= sck_s;
      pd_d_reg <= POWER_DOWN;
      if (state_reg == ST_CONV) begin
        conv_cnt_reg <= conv_cnt_reg + 16'h0001;
      end else begin
        conv_cnt_reg <= 16'h0000;
      end
      if (start) begin
        conv_chan_reg <= CONTINUOUS_SCAN ? chan_reg : {CHANNEL_ADDR_HI_IN, CHANNEL_ADDR_LO_IN};
      end
      if (POWER_DOWN && !pd_d_reg && CONTINUOUS_SCAN) begin
        chan_reg <= `CH_ZERO; // (R11)
      end else if (conv_end && CONTINUOUS_SCAN) begin
        chan_reg <= chan_reg + `CH_ONE; // (R9)
      end
      if (conv_end) begin
        result_reg <= SAMPLE_DATA; // (R22) (R8) (R18)
      end
      // Serial load: previous result, internal on start, external on read
      if (serial_mode && !shifting && ((start && !ext_clk) || (read_evt && ext_clk))) begin
        shift_reg <= result_reg; // (R16)
        bits_left_reg <= `SER_BITS;
        serial_out_reg <= result_reg[`RES_MSB]; // (R18)
        sck_out_reg <= 1'b0;
      end else if (shifting && int_shift && sck_tick) begin
        sck_out_reg <= !sck_out_reg;
        // Bit changes on the same clock as the falling edge, so the rising edge sees it settled
        if (sck_out_reg) begin // (R18)
          shift_reg <= {shift_reg[`RES_MSB-1:0], 1'b0};
          serial_out_reg <= shift_reg[`RES_MSB-1];
          bits_left_reg <= bits_left_reg - `CNT_ONE;
        end
      end else if (shifting && ext_clk && sck_fall_ext) begin
        shift_reg <= {shift_reg[`RES_MSB-1:0], 1'b0};
        serial_out_reg <= shift_reg[`RES_MSB-1];
        bits_left_reg <= bits_left_reg - `CNT_ONE;
      end
      if (cs_n_s || !rc_s) begin
        read_en_reg <= 1'b0;
      end else if (read_evt) begin
        read_en_reg <= 1'b1;
      end
      // Re-sampled every cycle so a half select change follows at once
      if (!HALF_SELECT) begin // (R3)
        bus_reg <= result_reg[`RES_MSB:`HI_LSB]; // (R2)
      end else begin
        bus_reg <= {result_reg[`LO_MSB:0], `LOW_PAD}; // (R2)
      end
    end
  end

  assign BUSY_N = (state_reg == ST_IDLE); // (R8)
  assign HOLD = (state_reg == ST_CONV); // (R4)
  assign CONV_CHANNEL = conv_chan_reg;
  assign PARALLEL_BUS = bus_reg;
  assign PARALLEL_BUS_OE = OUTPUT_FORMAT_SELECT && read_en_reg && !cs_n_s && rc_s; // (R1) (R5)
  assign SERIAL_OUT = serial_out_reg;
  assign SERIAL_OUT_OE = serial_mode && shifting; // (R1)
  assign SHIFT_CLOCK_OUT = sck_out_reg;
  assign SHIFT_CLOCK_OE = int_shift; // (R20)
  assign CHANNEL_ADDR_HI_OUT = chan_reg[1];
  assign CHANNEL_ADDR_LO_OUT = chan_reg[0];
  assign CHANNEL_ADDR_OE = CONTINUOUS_SCAN; // (R21)
endmodule // adc_convert_and_readout_control

// [hdl/adc_ctrl_map.vh]
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH
`define RES_W 12
`define RES_MSB 11
`define HI_LSB 4
`define LO_MSB 3
`define CH_W 2
`define CH_ZERO 2'h0
`define CH_ONE 2'h1
`define RES_ZERO 12'h000
`define BYTE_ZERO 8'h00
`define LOW_PAD 4'h0
`define SER_BITS 4'hC
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define CLK_MHZ 40
`define CONV_TIME_NS 20000
`define CONV_CYCLES ((`CONV_TIME_NS * `CLK_MHZ + 999) / 1000)
`define SCLK_HALF_NS 250
`define SCLK_HALF_CYCLES ((`SCLK_HALF_NS * `CLK_MHZ) / 1000)
`endif

// [hdl/pin_sync.v]
`timescale 1ns/10ps
module pin_sync (
  input wire clk,
  input wire rst_n,
  input wire d,
  output wire q
);
  reg meta_reg;
  reg sync_reg;
  // First stage only feeds the second
  always @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end
  assign q = sync_reg;
endmodule // pin_sync

// [hdl/rate_div.v]
`timescale 1ns/10ps
`include "adc_ctrl_map.vh"
module rate_div (
  input wire clk,
  input wire rst_n,
  input wire run,
  output wire tick
);
  reg [15:0] cnt_reg;
  localparam [31:0] LIMIT_FULL = `SCLK_HALF_CYCLES - 1;
  wire [15:0] limit;
  assign limit = LIMIT_FULL[15:0];
  always @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt_reg <= 16'h0000;
    end else if (cnt_reg == limit) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
  assign tick = run && (cnt_reg == limit);
endmodule // rate_div

// [verification/adc_ctrl_asserts.sv]
`timescale 1ns/10ps
module adc_ctrl_chk (
  input wire CLK,
  input wire RSTN,
  input wire CS_N,
  input wire READ_CONVERT,
  input wire HALF_SELECT,
  input wire OUTPUT_FORMAT_SELECT,
  input wire CONTINUOUS_SCAN,
  input wire POWER_DOWN,
  input wire CLOCK_SOURCE_SELECT,
  input wire SHIFT_CLOCK_OE,
  input wire CHANNEL_ADDR_OE,
  input wire HOLD,
  input wire BUSY_N,
  input wire [7:0] PARALLEL_BUS,
  input wire PARALLEL_BUS_OE,
  input wire SERIAL_OUT_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  reg [10:0] lo_cnt;
  // Counter bounds the busy span; a repetition that long would crawl
  always @(posedge CLK) lo_cnt <= (!RSTN || BUSY_N) ? 11'h000 : lo_cnt + 11'h001;
  property p_sck_dir; SHIFT_CLOCK_OE == (!OUTPUT_FORMAT_SELECT && !CLOCK_SOURCE_SELECT); endproperty
  a_sck_dir: assert property (p_sck_dir) else $error("shift clock direction wrong");
  property p_ch_dir; CHANNEL_ADDR_OE == CONTINUOUS_SCAN; endproperty
  a_ch_dir: assert property (p_ch_dir) else $error("channel pin direction wrong");
  property p_hold; HOLD |-> !BUSY_N; endproperty
  a_hold: assert property (p_hold) else $error("hold outside busy");
  property p_start;
    $fell(READ_CONVERT) && !CS_N && !POWER_DOWN && BUSY_N && $past(BUSY_N) |-> ##[1:6] !BUSY_N;
  endproperty
  a_start: assert property (p_start) else $error("convert request not taken");
  property p_pd; (POWER_DOWN && BUSY_N)[*6] |=> BUSY_N || !POWER_DOWN; endproperty
  a_pd: assert property (p_pd) else $error("conversion during power down");
  property p_keep; (BUSY_N && $stable(HALF_SELECT))[*3] |-> $stable(PARALLEL_BUS); endproperty
  a_keep: assert property (p_keep) else $error("bus moved without cause");
  property p_low_half;
    PARALLEL_BUS_OE && HALF_SELECT && $past(HALF_SELECT) |-> PARALLEL_BUS[3:0] == 4'h0;
  endproperty
  a_low_half: assert property (p_low_half) else $error("lower byte padding wrong");
  property p_fmt; !(PARALLEL_BUS_OE && !OUTPUT_FORMAT_SELECT) && !(SERIAL_OUT_OE && OUTPUT_FORMAT_SELECT); endproperty
  a_fmt: assert property (p_fmt) else $error("output format mixed");
  property p_len; $rose(BUSY_N) && OUTPUT_FORMAT_SELECT |-> lo_cnt >= 11'h31E && lo_cnt <= 11'h322; endproperty
  a_len: assert property (p_len) else $error("conversion span wrong");
  property p_bound; !BUSY_N |-> lo_cnt < 11'h3E8; endproperty
  a_bound: assert property (p_bound) else $error("busy stuck low");
endmodule // adc_ctrl_chk
bind adc_convert_and_readout_control adc_ctrl_chk u_chk (.*);

// [verification/host_sclk.sv]
`timescale 1ns/10ps
module host_sclk (
  input wire go,
  output logic sck
);
  // Clock stands low between frames; offset keeps it off the bench clock phase
  initial sck = 1'b0;
  always @(posedge go) begin
    #7;
    repeat (12) begin
      #100 sck = 1'b1;
      #100 sck = 1'b0;
    end
  end
endmodule // host_sclk

// [verification/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  logic CLK, RSTN, CS_N, READ_CONVERT, HALF_SELECT, OUTPUT_FORMAT_SELECT, CONTINUOUS_SCAN;
  logic POWER_DOWN, CLOCK_SOURCE_SELECT, SHIFT_CLOCK_IN, SHIFT_CLOCK_OUT, SHIFT_CLOCK_OE;
  logic CHANNEL_ADDR_HI_OUT, CHANNEL_ADDR_LO_OUT, CHANNEL_ADDR_OE, HOLD, BUSY_N, sck_go;
  logic PARALLEL_BUS_OE, SERIAL_OUT, SERIAL_OUT_OE;
  logic [1:0] CONV_CHANNEL, chan_in;
  logic [7:0] PARALLEL_BUS;
  logic [11:0] SAMPLE_DATA, got;
  int num_errors, checked;
  adc_convert_and_readout_control DUT (.CLK(CLK), .RSTN(RSTN), .CS_N(CS_N),
    .READ_CONVERT(READ_CONVERT), .HALF_SELECT(HALF_SELECT),
    .OUTPUT_FORMAT_SELECT(OUTPUT_FORMAT_SELECT), .CONTINUOUS_SCAN(CONTINUOUS_SCAN),
    .POWER_DOWN(POWER_DOWN), .CLOCK_SOURCE_SELECT(CLOCK_SOURCE_SELECT),
    .SHIFT_CLOCK_IN(SHIFT_CLOCK_IN), .SHIFT_CLOCK_OUT(SHIFT_CLOCK_OUT),
    .SHIFT_CLOCK_OE(SHIFT_CLOCK_OE), .CHANNEL_ADDR_HI_IN(chan_in[1]),
    .CHANNEL_ADDR_LO_IN(chan_in[0]), .CHANNEL_ADDR_HI_OUT(CHANNEL_ADDR_HI_OUT),
    .CHANNEL_ADDR_LO_OUT(CHANNEL_ADDR_LO_OUT), .CHANNEL_ADDR_OE(CHANNEL_ADDR_OE),
    .SAMPLE_DATA(SAMPLE_DATA), .HOLD(HOLD), .CONV_CHANNEL(CONV_CHANNEL), .BUSY_N(BUSY_N),
    .PARALLEL_BUS(PARALLEL_BUS), .PARALLEL_BUS_OE(PARALLEL_BUS_OE),
    .SERIAL_OUT(SERIAL_OUT), .SERIAL_OUT_OE(SERIAL_OUT_OE));
  host_sclk u_host (.go(sck_go), .sck(SHIFT_CLOCK_IN));
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (BUSY_N !== lvl && n < 1200) begin
      @(negedge CLK);
      n++;
    end
    check(BUSY_N, lvl);
  endtask
  task automatic convert();
    @(posedge CLK) READ_CONVERT <= 1'b0;
    repeat (4) @(posedge CLK);
    READ_CONVERT <= 1'b1;
  endtask
  // Samples mid-cycle, where the serial bit is settled around each clock rise
  task automatic shift_in(input logic ext, output logic [11:0] v);
    logic p, c;
    int n, k;
    p = 1'b0;
    c = 1'b0;
    v = 12'h000;
    n = 0;
    k = 0;
    while (n < 1200 && !(k == 12 && !c)) begin
      @(negedge CLK);
      c = ext ? SHIFT_CLOCK_IN : SHIFT_CLOCK_OUT;
      if (c && !p) begin
        v = {v[10:0], SERIAL_OUT};
        k++;
      end
      p = c;
      n++;
    end
    check(k, 12);
  endtask
  initial begin
    repeat (20000) @(posedge CLK);
    num_errors++;
    print_verdict();
  end
  initial begin
    {RSTN, HALF_SELECT, CONTINUOUS_SCAN, POWER_DOWN, CLOCK_SOURCE_SELECT, sck_go} = 6'h00;
    {CS_N, READ_CONVERT, OUTPUT_FORMAT_SELECT} = 3'h7;
    chan_in = 2'h2;
    SAMPLE_DATA = 12'hA5C;
    num_errors = 0;
    checked = 0;
    repeat (3) @(posedge CLK);
    RSTN <= 1'b1;
    repeat (3) @(posedge CLK);
    check(BUSY_N, 1'b1);
    CS_N <= 1'b0;
    convert();
    wait_busy(1'b0);
    check(HOLD, 1'b1);
    check(CONV_CHANNEL, 2'h2);
    convert();
    wait_busy(1'b1);
    repeat (2) @(posedge CLK);
    check(PARALLEL_BUS, 8'hA5);
    HALF_SELECT <= 1'b1;
    repeat (2) @(posedge CLK);
    check(PARALLEL_BUS, 8'hC0);
    check(PARALLEL_BUS_OE, 1'b1);
    repeat (220) @(posedge CLK);
    check(BUSY_N, 1'b1);
    POWER_DOWN <= 1'b1;
    SAMPLE_DATA <= 12'h3E7;
    convert();
    repeat (10) @(posedge CLK);
    check(BUSY_N, 1'b1);
    check(PARALLEL_BUS, 8'hC0);
    POWER_DOWN <= 1'b0;
    CS_N <= 1'b1;
    READ_CONVERT <= 1'b0;
    repeat (4) @(posedge CLK);
    CS_N <= 1'b0;
    wait_busy(1'b0);
    @(posedge CLK) READ_CONVERT <= 1'b1;
    wait_busy(1'b1);
    repeat (200) @(posedge CLK);
    check(PARALLEL_BUS, 8'h70);
    OUTPUT_FORMAT_SELECT <= 1'b0;
    SAMPLE_DATA <= 12'h81F;
    convert();
    shift_in(1'b0, got);
    check(got, 12'h3E7);
    wait_busy(1'b1);
    @(posedge CLK) CLOCK_SOURCE_SELECT <= 1'b1;
    CS_N <= 1'b1;
    repeat (3) @(posedge CLK);
    CS_N <= 1'b0;
    repeat (6) @(posedge CLK);
    sck_go <= 1'b1;
    shift_in(1'b1, got);
    check(got, 12'h81F);
    @(posedge CLK) CLOCK_SOURCE_SELECT <= 1'b0;
    CONTINUOUS_SCAN <= 1'b1;
    READ_CONVERT <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      wait_busy(1'b0);
      check(CONV_CHANNEL, i[1:0]);
      check({CHANNEL_ADDR_HI_OUT, CHANNEL_ADDR_LO_OUT}, i[1:0]);
      wait_busy(1'b1);
    end
    // A fifth scan leaves the counter on channel 1, so the reset is visible
    wait_busy(1'b0);
    wait_busy(1'b1);
    @(posedge CLK) POWER_DOWN <= 1'b1;
    repeat (4) @(posedge CLK);
    check({CHANNEL_ADDR_HI_OUT, CHANNEL_ADDR_LO_OUT}, 2'h0);
    print_verdict();
  end
endmodule // tb_top
